// ==== logic/pmcap_top.sv ====
// power-management capability structure seen through configuration cycles
`timescale 1ns/1ps

module pmcap_top
  import pmcap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pmcap_pkg::pmcap_cfg_req_s cfg_req,
  output pmcap_pkg::pmcap_cfg_rsp_s cfg_rsp,
  input wire logic change_irq_enable,
  input wire logic change_flag_clear,
  output logic power_state_changed_flag,
  output logic power_state_change_irq,
  output logic [1:0] device_mode_pci_status
);
  import pmcap_pkg::*;

  // ****************************************************
  // elaboration checks
  // ****************************************************
  // the write path and the read mux both lean on this field layout
  if (PMCAP_CTRL_LANE != (PMCAP_PS_LSB / 8))
  begin : g_bad_lane
    $error("write lane must be the lane holding the power state field");
  end
  if ((PMCAP_PS_LSB % 8) + 2 > 8)
  begin : g_bad_ps
    $error("power state field must not straddle two byte lanes");
  end
  if (PMCAP_WAKE_EN_BIT < PMCAP_PS_LSB + 2)
  begin : g_bad_en
    $error("wake enable bit overlaps the power state field");
  end
  if (PMCAP_WAKE_SUPPORT_LSB + 5 > 16)
  begin : g_bad_wake
    $error("wake support field runs past the capability word");
  end
  if (PMCAP_REVISION_LSB + 3 > 16)
  begin : g_bad_rev
    $error("revision field runs past the capability word");
  end
  if ((PMCAP_CTRL_WORD_OFS[1:0] != 2'b00) || (PMCAP_CAP_ID_OFS[1:0] != 2'b00))
  begin : g_bad_ofs
    $error("decoded offsets must be dword aligned");
  end
  if (PMCAP_CAP_WORD_OFS != PMCAP_CAP_ID_OFS + 8'h02)
  begin : g_bad_cap
    $error("capability word must follow the two header bytes");
  end

  // ****************************************************
  // access sequencer
  // ****************************************************
  typedef enum logic [1:0] {
    PMCAP_ST_IDLE = 2'b01,
    PMCAP_ST_RESP = 2'b10
  } pmcap_state_e;

  pmcap_state_e state_q;
  pmcap_state_e state_d;
  pmcap_cfg_rsp_s rsp_q;
  pmcap_cfg_rsp_s rsp_d;
  logic take;
  logic mux_hit;
  logic [31:0] mux_rdata;

  // one request at a time; the answer slot gives the host a clean ack pulse
  assign take = (state_q == PMCAP_ST_IDLE) && cfg_req.valid;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PMCAP_ST_IDLE:
      begin
        if (take)
        begin
          state_d = PMCAP_ST_RESP;
        end
      end
      PMCAP_ST_RESP:
      begin
        state_d = PMCAP_ST_IDLE;
      end
      default:
      begin
        state_d = PMCAP_ST_IDLE;
      end
    endcase
  end

  // ****************************************************
  // power state and change tracking
  // ****************************************************
  logic [1:0] ps_q;
  logic [1:0] ps_d;
  logic flag_q;
  logic flag_d;
  logic irq_q;
  logic irq_d;
  logic ctrl_write;
  logic [1:0] ps_new;
  logic ps_legal;
  logic ps_changed;
  logic ctrl_dword_sel;

  // whole-dword decode: the two low address bits never take part
  assign ctrl_dword_sel = ({cfg_req.addr[7:2], 2'b00} == PMCAP_CTRL_WORD_OFS);
  // only byte lane 0 of the control dword carries writable bits
  assign ctrl_write = take && cfg_req.write && ctrl_dword_sel
    && cfg_req.byte_en[PMCAP_CTRL_LANE];
  assign ps_new = cfg_req.wdata[PMCAP_PS_LSB +: 2];
  // reserved encodings are dropped rather than stored
  assign ps_legal = (ps_new == PMCAP_PS_FULL_ON) || (ps_new == PMCAP_PS_HOT_OFF);
  assign ps_changed = ctrl_write && ps_legal && (ps_new != ps_q);

  always_comb
  begin
    ps_d = ps_q;
    if (ctrl_write && ps_legal)
    begin
      ps_d = ps_new;
    end
  end

  always_comb
  begin
    flag_d = flag_q;
    if (change_flag_clear)
    begin
      flag_d = 1'b0;
    end
    // a change in the clearing cycle still lands
    if (ps_changed)
    begin
      flag_d = 1'b1;
    end
    irq_d = flag_d && change_irq_enable;
  end

  // ****************************************************
  // answer assembly
  // ****************************************************
  pmcap_read_mux u_read_mux (
    .addr(cfg_req.addr),
    .byte_en(cfg_req.byte_en),
    .power_state_field(ps_d),
    .hit(mux_hit),
    .rdata(mux_rdata)
  );

  always_comb
  begin
    rsp_d = '0;
    if (take)
    begin
      rsp_d.ack = 1'b1;
      rsp_d.hit = mux_hit;
      // writes return zero data; the value read shows the state after the access
      rsp_d.rdata = cfg_req.write ? 32'h00000000 : mux_rdata;
    end
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= PMCAP_ST_IDLE;
      rsp_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      rsp_q <= rsp_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ps_q <= PMCAP_PS_RESET;
    end
    else
    begin
      ps_q <= ps_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flag_q <= PMCAP_FLAG_RESET;
      irq_q <= PMCAP_FLAG_RESET;
    end
    else
    begin
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  assign cfg_rsp = rsp_q;
  assign power_state_changed_flag = flag_q;
  assign power_state_change_irq = irq_q;
  assign device_mode_pci_status = ps_q;

endmodule // pmcap_top

// ==== logic/pmcap_pkg.sv ====
// constants and carrier types of the power-management capability block
package pmcap_pkg;

  // ****************************************************
  // configuration-space offsets
  // ****************************************************
  localparam logic [7:0] PMCAP_CAP_ID_OFS = 8'hDC;
  localparam logic [7:0] PMCAP_NEXT_PTR_OFS = 8'hDD;
  localparam logic [7:0] PMCAP_CAP_WORD_OFS = 8'hDE;
  localparam logic [7:0] PMCAP_CTRL_WORD_OFS = 8'hE0;

  // ****************************************************
  // fixed values and field positions
  // ****************************************************
  localparam logic [7:0] PMCAP_CAP_ID_VAL = 8'h01;
  localparam logic [7:0] PMCAP_NEXT_PTR_VAL = 8'h00;
  localparam int PMCAP_WAKE_SUPPORT_LSB = 11;
  localparam logic [4:0] PMCAP_WAKE_SUPPORT_VAL = 5'h00;
  localparam int PMCAP_MID_LOW_BIT = 10;
  localparam int PMCAP_LIGHT_LOW_BIT = 9;
  localparam int PMCAP_DEV_INIT_BIT = 5;
  localparam int PMCAP_WAKE_CLK_BIT = 3;
  localparam int PMCAP_REVISION_LSB = 0;
  localparam logic [2:0] PMCAP_REVISION_VAL = 3'h2;
  localparam int PMCAP_WAKE_FLAG_BIT = 15;
  localparam int PMCAP_WAKE_EN_BIT = 8;
  localparam int PMCAP_PS_LSB = 0;
  localparam logic [1:0] PMCAP_PS_RESET = 2'h0;
  localparam logic PMCAP_FLAG_RESET = 1'b0;
  localparam int PMCAP_CTRL_LANE = 0;

  // ****************************************************
  // power states
  // ****************************************************
  typedef enum logic [1:0] {
    PMCAP_PS_FULL_ON = 2'h0,
    PMCAP_PS_RSVD1 = 2'h1,
    PMCAP_PS_RSVD2 = 2'h2,
    PMCAP_PS_HOT_OFF = 2'h3
  } pmcap_ps_e;

  // ****************************************************
  // configuration access carriers
  // ****************************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } pmcap_cfg_req_s;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
  } pmcap_cfg_rsp_s;

endpackage

// ==== logic/pmcap_read_mux.sv ====
// read-data selection for the two capability dwords
`timescale 1ns/1ps

module pmcap_read_mux
  import pmcap_pkg::*;
(
  input wire logic [7:0] addr,
  input wire logic [3:0] byte_en,
  input wire logic [1:0] power_state_field,
  output logic hit,
  output logic [31:0] rdata
);
  import pmcap_pkg::*;

  logic [15:0] cap_word;
  logic [15:0] ctrl_word;
  logic [31:0] raw;

  always_comb
  begin
    cap_word = 16'h0000;
    cap_word[PMCAP_WAKE_SUPPORT_LSB +: 5] = PMCAP_WAKE_SUPPORT_VAL;
    cap_word[PMCAP_MID_LOW_BIT] = 1'b0;
    cap_word[PMCAP_LIGHT_LOW_BIT] = 1'b0;
    cap_word[PMCAP_DEV_INIT_BIT] = 1'b0;
    cap_word[PMCAP_WAKE_CLK_BIT] = 1'b0;
    cap_word[PMCAP_REVISION_LSB +: 3] = PMCAP_REVISION_VAL;
    ctrl_word = 16'h0000;
    ctrl_word[PMCAP_WAKE_FLAG_BIT] = 1'b0;
    ctrl_word[PMCAP_WAKE_EN_BIT] = 1'b0;
    ctrl_word[PMCAP_PS_LSB +: 2] = power_state_field;
    raw = 32'h00000000;
    hit = 1'b0;
    case ({addr[7:2], 2'b00})
      PMCAP_CAP_ID_OFS:
      begin
        raw = {cap_word, PMCAP_NEXT_PTR_VAL, PMCAP_CAP_ID_VAL};
        hit = 1'b1;
      end
      PMCAP_CTRL_WORD_OFS:
      begin
        raw = {16'h0000, ctrl_word};
        hit = 1'b1;
      end
      default:
      begin
        raw = 32'h00000000;
        hit = 1'b0;
      end
    endcase
  end

  // unselected lanes read zero so a narrow read never shows stale neighbours
  for (genvar lane = 0; lane < 4; lane++)
  begin : g_lane
    assign rdata[lane*8 +: 8] = byte_en[lane] ? raw[lane*8 +: 8] : 8'h00;
  end

endmodule // pmcap_read_mux

// ==== dv/pmcap_chk.sv ====
// port assertions for the capability block
`timescale 1ns/1ps
module pmcap_chk
  import pmcap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pmcap_pkg::pmcap_cfg_req_s cfg_req,
  input wire pmcap_pkg::pmcap_cfg_rsp_s cfg_rsp,
  input wire logic change_irq_enable,
  input wire logic change_flag_clear,
  input wire logic power_state_changed_flag,
  input wire logic power_state_change_irq,
  input wire logic [1:0] device_mode_pci_status
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_cap_dword: assert property (
    cfg_rsp.ack && !$past(cfg_req.write)
    && $past(cfg_req.addr[7:2]) == 6'h37 && $past(cfg_req.byte_en) == 4'hF
    |-> cfg_rsp.hit && cfg_rsp.rdata == 32'h0002_0001) else $error("cap dword");
  a_ctrl_dword: assert property (cfg_rsp.ack && !$past(cfg_req.write)
    && $past(cfg_req.addr[7:2]) == 6'h38 && $past(cfg_req.byte_en) == 4'hF
    |-> cfg_rsp.rdata == {30'h0, device_mode_pci_status}) else $error("ctrl dword");
  a_miss_zero: assert property (cfg_rsp.ack && !cfg_rsp.hit |-> cfg_rsp.rdata == 0)
    else $error("miss data");
  a_state_legal: assert property (!(device_mode_pci_status inside {2'h1, 2'h2}))
    else $error("reserved state");
  a_change_flag: assert property ($changed(device_mode_pci_status)
    |-> power_state_changed_flag) else $error("flag not set");
  a_change_cause: assert property ($changed(device_mode_pci_status)
    |-> cfg_rsp.ack && $past(cfg_req.write) && $past(cfg_req.byte_en[0])) else $error("mirror");
  a_irq_gate: assert property (power_state_change_irq
    == (power_state_changed_flag && $past(change_irq_enable))) else $error("irq");
  a_flag_clear: assert property (change_flag_clear |=> !power_state_changed_flag
    || $changed(device_mode_pci_status)) else $error("flag clear");
  a_ack_pulse: assert property (cfg_req.valid && !cfg_rsp.ack
    |=> cfg_rsp.ack ##1 !cfg_rsp.ack) else $error("ack timing");
  c_hot_off: cover property (device_mode_pci_status == 2'h3);
  c_irq: cover property (power_state_change_irq);
  c_miss: cover property (cfg_rsp.ack && !cfg_rsp.hit);
  c_set_wins: cover property (change_flag_clear && cfg_req.valid && !cfg_rsp.ack
    ##1 power_state_changed_flag);
endmodule // pmcap_chk

bind pmcap_top pmcap_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_req(cfg_req),
  .cfg_rsp(cfg_rsp), .change_irq_enable(change_irq_enable),
  .change_flag_clear(change_flag_clear), .power_state_changed_flag(power_state_changed_flag),
  .power_state_change_irq(power_state_change_irq),
  .device_mode_pci_status(device_mode_pci_status));

// ==== dv/pmcap_host_model.sv ====
// host model issuing configuration cycles
`timescale 1ns/1ps
module pmcap_host_model
  import pmcap_pkg::*;
(
  input wire logic ref_clk,
  output pmcap_pkg::pmcap_cfg_req_s cfg_req,
  input wire pmcap_pkg::pmcap_cfg_rsp_s cfg_rsp
);
  initial cfg_req = '0;
  // request held until ack; idle bus scrambled so stale values never match
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d, output logic [31:0] rd, output logic h, output bit to);
    int n;
    rd = '0;
    h = 1'b0;
    to = 1'b1;
    @(negedge ref_clk);
    cfg_req <= '{1'b1, w, a, be, d};
    for (n = 0; n < 8 && to; n++)
    begin
      @(posedge ref_clk);
      if (cfg_rsp.ack === 1'b1)
      begin
        to = 1'b0;
        rd = cfg_rsp.rdata;
        h = cfg_rsp.hit;
      end
    end
    @(negedge ref_clk);
    cfg_req <= {1'b0, ~cfg_req[44:0]};
  endtask
endmodule // pmcap_host_model

// ==== dv/tb_top.sv ====
// self-checking bench for the capability block
`timescale 1ns/1ps
module tb_top;
  import pmcap_pkg::*;
  logic ref_clk;
  logic rst_b;
  logic change_irq_enable;
  logic change_flag_clear;
  pmcap_cfg_req_s cfg_req;
  pmcap_cfg_rsp_s cfg_rsp;
  logic flag;
  logic irq;
  logic [1:0] mirror;
  int n_errors = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic hit;
  bit to;
  pmcap_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
    .change_irq_enable(change_irq_enable), .change_flag_clear(change_flag_clear),
    .power_state_changed_flag(flag), .power_state_change_irq(irq),
    .device_mode_pci_status(mirror));
  pmcap_host_model i_host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [31:0] exp);
    cmp_count++;
    if (rd !== exp)
    begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, rd);
    end
  endtask
  // status vector is {flag, irq, mirror}
  task automatic cmp_st(input logic [3:0] exp);
    cmp_count++;
    if ({flag, irq, mirror} !== exp)
    begin
      n_errors++;
      $display("BAD status exp %h got %h", exp, {flag, irq, mirror});
    end
  endtask
  task automatic cmp_hit(input logic exp);
    cmp_count++;
    if (hit !== exp)
    begin
      n_errors++;
      $display("BAD hit exp %h got %h", exp, hit);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
    input logic [31:0] d);
    i_host.cfg(w, a, be, d, rd, hit, to);
    if (to)
    begin
      n_errors++;
      $display("BAD ack exp 1 got 0");
      complete_run();
    end
  endtask
  task automatic t_reset_view;
    acc(1'b0, 8'hDC, 4'hF, 32'h0);
    cmp_word("cap", 32'h0002_0001);
    cmp_hit(1'b1);
    acc(1'b0, 8'hE0, 4'hF, 32'h0);
    cmp_word("ctrl", 32'h0);
    cmp_hit(1'b1);
    cmp_st(4'h0);
  endtask
  // clear landing on the very edge of a change must lose to the change
  task automatic t_set_wins;
    acc(1'b1, 8'hE0, 4'h1, 32'h3);
    cmp_st(4'hB);
    fork
      acc(1'b1, 8'hE0, 4'h1, 32'h0);
      begin
        @(negedge ref_clk);
        change_flag_clear = 1'b1;
        @(negedge ref_clk);
        change_flag_clear = 1'b0;
      end
    join
    cmp_st(4'h8);
    change_flag_clear = 1'b1;
    @(negedge ref_clk);
    change_flag_clear = 1'b0;
    cmp_st(4'h0);
  endtask
  task automatic t_state_change;
    change_irq_enable = 1'b1;
    acc(1'b1, 8'hE0, 4'h1, 32'h3);
    cmp_st(4'hF);
    change_flag_clear = 1'b1;
    @(negedge ref_clk);
    change_flag_clear = 1'b0;
    cmp_st(4'h3);
    acc(1'b1, 8'hE0, 4'h1, 32'h1);
    cmp_st(4'h3);
    change_irq_enable = 1'b0;
    acc(1'b1, 8'hE0, 4'h1, 32'h0);
    cmp_st(4'h8);
    change_flag_clear = 1'b1;
    @(negedge ref_clk);
    change_flag_clear = 1'b0;
  endtask
  task automatic t_reserved;
    acc(1'b1, 8'hE0, 4'hF, 32'hFFFF_FFFF);
    acc(1'b0, 8'hE0, 4'hF, 32'h0);
    cmp_word("ctrl", 32'h3);
    acc(1'b1, 8'hE0, 4'hE, 32'h0);
    cmp_st(4'hB);
    acc(1'b1, 8'hDC, 4'hF, 32'h0);
    acc(1'b0, 8'hDE, 4'hF, 32'h0);
    cmp_word("cap", 32'h0002_0001);
    acc(1'b0, 8'hDE, 4'hC, 32'h0);
    cmp_word("cap half", 32'h0002_0000);
    acc(1'b0, 8'h40, 4'hF, 32'h0);
    cmp_word("miss", 32'h0);
    cmp_hit(1'b0);
    rst_b = 1'b0;
    @(negedge ref_clk);
    cmp_st(4'h0);
    rst_b = 1'b1;
  endtask
  initial
  begin
    rst_b = 1'b0;
    change_irq_enable = 1'b0;
    change_flag_clear = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset_view();
    t_state_change();
    t_set_wins();
    t_reserved();
    t_reset_view();
    complete_run();
  end
endmodule // tb_top
